/* common/ebc_defs.svh */
// offsets, field positions, reset values and counts of the area config bank
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// printed offsets are not word aligned: each is an index, byte addr = 4*index
`define EBC_IDX_AREA_BUS_WIDTH       16'hffec
`define EBC_IDX_AREA_ACCESS_STATES   16'hffed
`define EBC_IDX_WAIT_CONTROL         16'hffee
`define EBC_IDX_AREA_WAIT_ENABLE     16'hffef
`define EBC_IDX_BUS_RELEASE_CONTROL  16'hfff3

`define EBC_RST_WIDTH_MODES13        8'hff
`define EBC_RST_WIDTH_MODES24        8'h00
`define EBC_RST_ACCESS_STATES        8'hff
`define EBC_RST_WAIT_CONTROL         8'hf3
`define EBC_RST_AREA_WAIT_ENABLE     8'hff
`define EBC_RST_BUS_RELEASE_CONTROL  8'hfe

// wait control fields
`define EBC_WC_COUNT_LSB             0
`define EBC_WC_MODE_LSB              2
`define EBC_WC_FIXED_MASK            8'hf0
`define EBC_WC_RW_MASK               8'h0f

// bus release control fields
`define EBC_BR_RELEASE_BIT           0
`define EBC_BR_ADDR_EN_LSB           5
`define EBC_BR_FIXED_MASK            8'h1e
`define EBC_BR_ADDR_MASK             8'he0
`define EBC_BR_RW_MASK               8'he1

// all-ones width register means 8-bit bus mode
`define EBC_ALL_AREAS_8BIT           8'hff

// straps load at the third edge after reset release, once both sync flops
// hold the pin value rather than their reset value
`define EBC_STRAP_SETTLE             2'h3

// on-chip space: fixed 16-bit width, fixed two-state access
`define EBC_ONCHIP_WIDE              1'b1
`define EBC_ONCHIP_STATES3           1'b0

`define EBC_RESP_OKAY                2'h0
`define EBC_RESP_SLVERR              2'h2

`endif

/* common/ebc_pkg.sv */
// types shared by the external bus area configuration bank
package ebc_pkg;

  typedef enum logic [1:0] {
    EBC_WAIT_PROGRAMMABLE = 2'h0,
    EBC_WAIT_NONE         = 2'h1,
    EBC_WAIT_PIN1         = 2'h2,
    EBC_WAIT_PIN_AUTO     = 2'h3
  } ebc_wait_mode_t;

  typedef enum {
    EBC_BUS_OWNED,
    EBC_BUS_RELEASED
  } ebc_release_state_t;

endpackage

/* core/ebc_sync.sv */
// two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/1ns
`default_nettype none

module ebc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  if (W < 1) begin : g_bad_width
    $error("ebc_sync: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic stage1_q;
    logic stage2_q;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stage1_q <= RST_VAL[i];
        stage2_q <= RST_VAL[i];
      end else begin
        stage1_q <= asyncIn[i];
        stage2_q <= stage1_q;
      end
    end
    assign syncOut[i] = stage2_q;
  end

endmodule

`default_nettype wire

/* core/ebc_area_config.sv */
// external bus area configuration registers with axi4-lite access
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ebc_defs.svh"

// Summary of operation
// [R1] five registers at fixed offsets, width first
// [R2] all width bits one: 8-bit bus mode
// [R3] any width bit zero: 16-bit bus
// [R4] width reset ones modes 1,3, zeros 2,4
// [R5] software standby keeps every register
// [R6] per area: 0 16-bit, 1 8-bit
// [R7] on-chip accesses use fixed width
// [R8] per area: 0 two states, 1 three
// [R9] on-chip accesses use fixed state count
// [R10] wait mode field selects four wait modes
// [R11] wait count field inserts 0..3 waits
// [R12] wait control resets f3, upper nibble ones
// [R13] per area wait controller enable, reset ones
// [R14] zero address enable bit drives A23..A21
// [R15] outside modes 3,4 address enables frozen
// [R16] release control resets fe, bits 4..1 ones
// [R17] release enable zero: never release bus
// [R18] external master holds request until done
// [R19] acknowledge asserted while bus released
// [R20] wait pin only for three-state areas
// [R21] new settings start at next bus cycle; address enables here change even inside a bus cycle
module ebc_area_config
  import ebc_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // device pins: mode straps, standby, external master request
  input  wire logic [2:0]        opModePins,
  input  wire logic              hwStandbyPin,
  input  wire logic              bus_request_n,
  output logic                   busAck_n,
  // bus cycle engine
  input  wire logic              busCycleActive,
  input  wire logic [2:0]        accessArea,
  input  wire logic              accessExternal,
  output logic                   accessWide,
  output logic                   accessStates3,
  output logic                   accessWaitCtrlEn,
  output logic [1:0]             accessWaitCount,
  output logic                   accessWaitPinHonored,
  output ebc_wait_mode_t         waitMode,
  output logic                   busMode8,
  output logic                   lowerDataPortGpio,
  output logic [2:0]             addrPinEnable,
  output logic                   busReqAckPinsGpio
);

  if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ebc_area_config: ADDR_W must be 18..32 to reach the map");
  end

  // pin synchronisers
  logic [2:0] opModeSync;
  logic       hwStandbySync;
  logic       busReqSync_n;

  ebc_sync #(.W(5), .RST_VAL(5'h10)) u_pinSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({bus_request_n, hwStandbyPin, opModePins}),
    .syncOut ({busReqSync_n, hwStandbySync, opModeSync})
  );

  logic modes13;
  logic modes34;
  assign modes13 = (opModeSync == 3'h1) || (opModeSync == 3'h3);
  assign modes34 = (opModeSync == 3'h3) || (opModeSync == 3'h4);

  logic [7:0] widthResetVal;
  assign widthResetVal = modes13 ? `EBC_RST_WIDTH_MODES13     // [R4]
                                 : `EBC_RST_WIDTH_MODES24;

  // straps are caught only once they have crossed the synchroniser
  logic [1:0] strapWait_q;
  logic       strapLoad;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapWait_q <= 2'h0;
    end else if (strapWait_q != `EBC_STRAP_SETTLE) begin
      strapWait_q <= strapWait_q + 2'h1;
    end
  end
  assign strapLoad = (strapWait_q == (`EBC_STRAP_SETTLE - 2'h1));

  // reinit on reset, the strap load or hardware standby, never otherwise
  logic reinit;
  assign reinit = strapLoad || hwStandbySync;                // [R5]

  // axi write channel
  logic [ADDR_W-1:0] awAddr_q;
  logic              awHeld_q;
  logic [7:0]        wData_q;
  logic              wLane0_q;
  logic              wHeld_q;
  logic              bValid_q;
  logic [1:0]        bResp_q;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awAddr_q <= '0;
      awHeld_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awAddr_q <= s_axi_awaddr;
      awHeld_q <= 1'b1;
    end else if (awHeld_q && wHeld_q) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wData_q  <= 8'h00;
      wLane0_q <= 1'b0;
      wHeld_q  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wData_q  <= s_axi_wdata[7:0];
      wLane0_q <= s_axi_wstrb[0];
      wHeld_q  <= 1'b1;
    end else if (awHeld_q && wHeld_q) begin
      wHeld_q <= 1'b0;
    end
  end

  function automatic logic [2:0] decodeIdx(input logic [ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[17:2];
    case (idx)                                                 // [R1]
      `EBC_IDX_AREA_BUS_WIDTH:      decodeIdx = 3'h1;
      `EBC_IDX_AREA_ACCESS_STATES:  decodeIdx = 3'h2;
      `EBC_IDX_WAIT_CONTROL:        decodeIdx = 3'h3;
      `EBC_IDX_AREA_WAIT_ENABLE:    decodeIdx = 3'h4;
      `EBC_IDX_BUS_RELEASE_CONTROL: decodeIdx = 3'h5;
      default:                      decodeIdx = 3'h0;
    endcase
    if ((a >> 18) != '0) begin
      decodeIdx = 3'h0;
    end
  endfunction

  logic       doWrite;
  logic [2:0] wSel;
  logic       wEn;
  assign doWrite = awHeld_q && wHeld_q;
  assign wSel    = decodeIdx(awAddr_q);
  assign wEn     = doWrite && wLane0_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q  <= `EBC_RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q  <= (wSel == 3'h0) ? `EBC_RESP_SLVERR : `EBC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // configuration registers
  logic [7:0] areaWidth_q;
  logic [7:0] areaStates_q;
  logic [3:0] waitCtrl_q;
  logic [7:0] areaWaitEn_q;
  logic [2:0] addrEnBits_q;
  logic       releaseEn_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      areaWidth_q <= `EBC_RST_WIDTH_MODES13;
    end else if (reinit) begin
      areaWidth_q <= widthResetVal;                            // [R4]
    end else if (wEn && wSel == 3'h1) begin
      areaWidth_q <= wData_q;                                  // [R6]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      areaStates_q <= `EBC_RST_ACCESS_STATES;
    end else if (reinit) begin
      areaStates_q <= `EBC_RST_ACCESS_STATES;                  // [R8]
    end else if (wEn && wSel == 3'h2) begin
      areaStates_q <= wData_q;                                 // [R8]
    end
  end

  // upper nibble is not stored: it is constant ones on read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCtrl_q <= 4'(`EBC_RST_WAIT_CONTROL);
    end else if (reinit) begin
      waitCtrl_q <= 4'(`EBC_RST_WAIT_CONTROL);                 // [R12]
    end else if (wEn && wSel == 3'h3) begin
      waitCtrl_q <= 4'(wData_q & `EBC_WC_RW_MASK);             // [R12]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      areaWaitEn_q <= `EBC_RST_AREA_WAIT_ENABLE;
    end else if (reinit) begin
      areaWaitEn_q <= `EBC_RST_AREA_WAIT_ENABLE;               // [R13]
    end else if (wEn && wSel == 3'h4) begin
      areaWaitEn_q <= wData_q;                                 // [R13]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrEnBits_q <= 3'(`EBC_RST_BUS_RELEASE_CONTROL
                         >> `EBC_BR_ADDR_EN_LSB);
      releaseEn_q  <= 1'b0;
    end else if (reinit) begin
      addrEnBits_q <= 3'(`EBC_RST_BUS_RELEASE_CONTROL
                         >> `EBC_BR_ADDR_EN_LSB);              // [R16]
      releaseEn_q  <= 1'(`EBC_RST_BUS_RELEASE_CONTROL
                         >> `EBC_BR_RELEASE_BIT);              // [R16]
    end else if (wEn && wSel == 3'h5) begin
      if (modes34) begin
        addrEnBits_q <= wData_q[`EBC_BR_ADDR_EN_LSB +: 3];    // [R14]
      end
      releaseEn_q <= wData_q[`EBC_BR_RELEASE_BIT];             // [R17]
    end
  end

  // effective address enables: outside modes 3,4 the pins stay ports
  logic [2:0] addrEnEff;
  assign addrEnEff = modes34 ? addrEnBits_q : 3'h7;            // [R15]

  logic [7:0] waitCtrlRead;
  logic [7:0] releaseRead;
  assign waitCtrlRead = `EBC_WC_FIXED_MASK | {4'h0, waitCtrl_q};
  assign releaseRead  = {addrEnEff, 4'h0, releaseEn_q}
                        | `EBC_BR_FIXED_MASK;                  // [R16]

  // axi read channel; data registered, one read outstanding
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic [2:0]  rSel;
  logic [7:0]  rByte;

  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign rSel          = decodeIdx(s_axi_araddr);

  always_comb begin
    case (rSel)
      3'h1:    rByte = areaWidth_q;
      3'h2:    rByte = areaStates_q;
      3'h3:    rByte = waitCtrlRead;                           // [R12]
      3'h4:    rByte = areaWaitEn_q;
      3'h5:    rByte = releaseRead;
      default: rByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= `EBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q  <= {24'h00_0000, rByte};
      rResp_q  <= (rSel == 3'h0) ? `EBC_RESP_SLVERR : `EBC_RESP_OKAY;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // settings seen by the bus engine, except the address enables, only change between bus cycles
  logic [7:0] appWidth_q;
  logic [7:0] appStates_q;
  logic [3:0] appWaitCtrl_q;
  logic [7:0] appWaitEn_q;
  logic       appRelease_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      appWidth_q    <= `EBC_RST_WIDTH_MODES13;
      appStates_q   <= `EBC_RST_ACCESS_STATES;
      appWaitCtrl_q <= 4'(`EBC_RST_WAIT_CONTROL);
      appWaitEn_q   <= `EBC_RST_AREA_WAIT_ENABLE;
      appRelease_q  <= 1'b0;
    end else if (!busCycleActive) begin                        // [R21]
      appWidth_q    <= areaWidth_q;
      appStates_q   <= areaStates_q;
      appWaitCtrl_q <= waitCtrl_q;
      appWaitEn_q   <= areaWaitEn_q;
      appRelease_q  <= releaseEn_q;
    end
  end

  // per access decode for the cycle engine
  logic areaIs8;
  logic areaIs3;
  assign areaIs8 = appWidth_q[accessArea];                     // [R6]
  assign areaIs3 = appStates_q[accessArea];                    // [R8]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accessWide           <= `EBC_ONCHIP_WIDE;
      accessStates3        <= `EBC_ONCHIP_STATES3;
      accessWaitCtrlEn     <= 1'b0;
      accessWaitCount      <= 2'h0;
      accessWaitPinHonored <= 1'b0;
    end else if (!accessExternal) begin
      accessWide           <= `EBC_ONCHIP_WIDE;                // [R7]
      accessStates3        <= `EBC_ONCHIP_STATES3;             // [R9]
      accessWaitCtrlEn     <= 1'b0;
      accessWaitCount      <= 2'h0;
      accessWaitPinHonored <= 1'b0;
    end else begin
      accessWide       <= !areaIs8;                            // [R6]
      accessStates3    <= areaIs3;                             // [R8]
      accessWaitCtrlEn <= areaIs3 && appWaitEn_q[accessArea];  // [R13]
      // programmable count used only in programmable and auto modes
      accessWaitCount  <= (areaIs3 && appWaitEn_q[accessArea]
                           && (appWaitCtrl_q[3:2] == 2'h0
                               || appWaitCtrl_q[3:2] == 2'h3))
                          ? appWaitCtrl_q[1:0] : 2'h0;         // [R11]
      // pin mode 0 (enable clear) and pin modes 1/auto listen to wait
      accessWaitPinHonored <= areaIs3                          // [R20]
                              && (!appWaitEn_q[accessArea]
                                  || appWaitCtrl_q[3]);        // [R10]
    end
  end

  // global modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busMode8          <= 1'b1;
      lowerDataPortGpio <= 1'b1;
      waitMode          <= EBC_WAIT_PROGRAMMABLE;
      addrPinEnable     <= 3'h0;
      busReqAckPinsGpio <= 1'b1;
    end else begin
      busMode8          <= (appWidth_q == `EBC_ALL_AREAS_8BIT); // [R2]
      lowerDataPortGpio <= (appWidth_q == `EBC_ALL_AREAS_8BIT); // [R3]
      waitMode          <= ebc_wait_mode_t'(appWaitCtrl_q[3:2]); // [R10]
      addrPinEnable     <= ~addrEnEff;                         // [R14]
      busReqAckPinsGpio <= !appRelease_q;                      // [R17]
    end
  end

  // bus release arbitration; request is held by the master while it works
  ebc_release_state_t relState_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relState_q <= EBC_BUS_OWNED;
    end else begin
      case (relState_q)
        EBC_BUS_OWNED: begin
          if (appRelease_q && !busReqSync_n && !busCycleActive) begin
            relState_q <= EBC_BUS_RELEASED;                    // [R17]
          end
        end
        EBC_BUS_RELEASED: begin
          if (busReqSync_n) begin
            relState_q <= EBC_BUS_OWNED;                       // [R18]
          end
        end
        default: relState_q <= EBC_BUS_OWNED;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busAck_n <= 1'b1;
    end else begin
      busAck_n <= !(relState_q == EBC_BUS_RELEASED);           // [R19]
    end
  end

endmodule

`default_nettype wire

/* verification/ebc_area_config_props.sv */
// assertions on the area configuration bank ports
`timescale 1ns/1ns
`default_nettype none

module ebc_area_config_props
  import ebc_pkg::*;
(
  // clock and reset
  input wire logic           clk,
  input wire logic           rst,
  // register read channel
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  // pins and engine side
  input wire logic [2:0]     opModePins,
  input wire logic           bus_request_n,
  input wire logic           busAck_n,
  input wire logic           busCycleActive,
  input wire logic           accessExternal,
  input wire logic           accessWide,
  input wire logic           accessStates3,
  input wire logic           accessWaitCtrlEn,
  input wire ebc_wait_mode_t waitMode,
  input wire logic           busMode8,
  input wire logic           lowerDataPortGpio,
  input wire logic [2:0]     addrPinEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_bus_mode; busMode8 == lowerDataPortGpio; endproperty
  a_bus_mode: assert property (p_bus_mode)
    else $error("bus mode and lower port disagree");
  property p_onchip;
    !accessExternal |=> accessWide && !accessStates3 && !accessWaitCtrlEn;
  endproperty
  a_onchip: assert property (p_onchip)
    else $error("on-chip access not fixed");
  property p_ack_cause; $fell(busAck_n) |-> !$past(bus_request_n, 2); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without request");
  property p_ack_end; $rose(bus_request_n) |-> ##[1:6] busAck_n; endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge kept after request ended");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late or too wide");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped before taken");
  // a setting must not land inside a running bus cycle
  property p_wait_hold;
    busCycleActive && $past(busCycleActive) |=> $stable(waitMode);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("wait mode changed during bus cycle");
  property p_addr; addrPinEnable != 3'h0 |-> opModePins inside {3'h3, 3'h4}; endproperty
  a_addr: assert property (p_addr)
    else $error("address pins enabled in wrong mode");
endmodule

bind ebc_area_config ebc_area_config_props i_ebc_area_config_props (
  .clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .opModePins, .bus_request_n, .busAck_n, .busCycleActive,
  .accessExternal, .accessWide, .accessStates3, .accessWaitCtrlEn, .waitMode,
  .busMode8, .lowerDataPortGpio, .addrPinEnable
);

`default_nettype wire

/* verification/ebc_ext_master.sv */
// external master that borrows the bus when the bench asks
`timescale 1ns/1ns
`default_nettype none

module ebc_ext_master #(
  parameter int HOLD = 15
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench command, device answer, request pin
  input  wire logic want,
  input  wire logic busAck_n,
  output logic      bus_request_n
);
  logic       reqN_q = 1'h1;
  logic [7:0] used_q = 8'h0;

  assign bus_request_n = reqN_q;

  // once granted, request stays low until the borrowed bus is used up
  always @(posedge clk or posedge rst) begin
    if (rst)
      reqN_q <= 1'h1;
    else
      reqN_q <= !(want || (!busAck_n && used_q < 8'(HOLD)));
  end

  always @(posedge clk or posedge rst) begin
    if (rst || busAck_n)
      used_q <= 8'h0;
    else if (used_q < 8'(HOLD))
      used_q <= used_q + 8'h1;
  end
endmodule

`default_nettype wire

/* verification/ebc_area_config_test.sv */
// self-checking bench for the area configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "ebc_defs.svh"

module ebc_area_config_test
  import ebc_pkg::*;
;
  localparam logic [15:0] WID = `EBC_IDX_AREA_BUS_WIDTH;
  localparam logic [15:0] AST = `EBC_IDX_AREA_ACCESS_STATES;
  localparam logic [15:0] WCT = `EBC_IDX_WAIT_CONTROL;
  localparam logic [15:0] WEN = `EBC_IDX_AREA_WAIT_ENABLE;
  localparam logic [15:0] BRC = `EBC_IDX_BUS_RELEASE_CONTROL;
  logic           clk = 1'h0, rst = 1'h1;
  logic [17:0]    awAddr = '0, arAddr = '0;
  logic [31:0]    wData = '0, rData;
  logic [3:0]     wStrb = 4'h1;
  logic           awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  logic           arValid = 1'h0, rReady = 1'h0;
  logic           awReady, wReady, bValid, arReady, rValid;
  logic [1:0]     bResp, rResp, waitCnt;
  logic [2:0]     opMode = 3'h1, area = 3'h0, addrEn;
  logic           hwStandby = 1'h0, busy = 1'h0, ext = 1'h0, want = 1'h0;
  logic           reqN, ackN, wide, st3, wce, honored, mode8, lowGpio, relGpio;
  ebc_wait_mode_t wMode;
  int             n_mismatch = 0, n_compared = 0, cycles = 0;

  ebc_area_config i_ebc_area_config (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .opModePins(opMode), .hwStandbyPin(hwStandby), .bus_request_n(reqN),
    .busAck_n(ackN), .busCycleActive(busy), .accessArea(area),
    .accessExternal(ext), .accessWide(wide), .accessStates3(st3),
    .accessWaitCtrlEn(wce), .accessWaitCount(waitCnt),
    .accessWaitPinHonored(honored), .waitMode(wMode), .busMode8(mode8),
    .lowerDataPortGpio(lowGpio), .addrPinEnable(addrEn),
    .busReqAckPinsGpio(relGpio)
  );
  ebc_ext_master i_ebc_ext_master (
    .clk(clk), .rst(rst), .want(want), .busAck_n(ackN), .bus_request_n(reqN)
  );

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // every task that drives a signal starts one edge on, so no strobe is driven twice in a step
  task automatic wr(input logic [15:0] ix, input logic [7:0] d,
                    output logic [1:0] r);
    logic a, w;
    a = 1'h0;
    w = 1'h0;
    @(posedge clk);
    awAddr <= {ix, 2'h0};
    wData <= {24'h0, d};
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    while (!(a && w)) begin
      @(posedge clk);
      if (awValid && awReady) a = 1'h1;
      if (wValid && wReady) w = 1'h1;
      if (a) awValid <= 1'h0;
      if (w) wValid <= 1'h0;
    end
    do @(posedge clk); while (!bValid);
    r = bResp;
    bReady <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] ix, output logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    arAddr <= {ix, 2'h0};
    arValid <= 1'h1;
    rReady <= 1'h1;
    do @(posedge clk); while (!arReady);
    arValid <= 1'h0;
    while (!rValid) @(posedge clk);
    d = rData[7:0];
    r = rResp;
    rReady <= 1'h0;
  endtask

  task automatic put(input logic [15:0] ix, input logic [7:0] d);
    logic [1:0] r;
    wr(ix, d, r);
    chk(r, `EBC_RESP_OKAY);
  endtask

  task automatic reg_is(input logic [15:0] ix, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(ix, d, r);
    chk({r, d}, {`EBC_RESP_OKAY, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reset_to(input logic [2:0] m);
    @(posedge clk);
    rst <= 1'h1;
    opMode <= m;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    tick(4);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [1:0] r;
    reg_is(WID, 8'hff);
    reg_is(AST, 8'hff);
    reg_is(WCT, 8'hf3);
    reg_is(WEN, 8'hff);
    reg_is(BRC, 8'hfe);
    chk({mode8, relGpio}, 2'h3);
    wr(16'hfff0, 8'h00, r);
    chk(r, `EBC_RESP_SLVERR);
    rd(16'hfff0, d, r);
    chk({r, d}, {`EBC_RESP_SLVERR, 8'h00});
    reg_is(WID, 8'hff);
  endtask

  task automatic t_access();
    logic [7:0] w, s, e;
    w = 8'h0f;
    s = 8'h55;
    e = 8'h33;
    put(WID, w);
    put(AST, s);
    put(WEN, e);
    put(WCT, 8'h02);
    for (int a = 0; a < 8; a++) begin
      @(posedge clk);
      ext <= 1'h1;
      area <= 3'(a);
      tick(2);
      chk(wide, !w[a]);
      chk(st3, s[a]);
      chk(wce, s[a] & e[a]);
      chk(waitCnt, (s[a] & e[a]) ? 2'h2 : 2'h0);
      chk(honored, s[a] & !e[a]);
    end
    chk({mode8, lowGpio}, 2'h0);
    @(posedge clk);
    ext <= 1'h0;
    tick(2);
    chk({wide, st3, wce, waitCnt}, 5'h10);
  endtask

  task automatic t_wait_modes();
    for (int m = 0; m < 4; m++) begin
      put(WCT, {6'h0, 2'(m)} << 2 | 8'h01);
      tick(3);
      reg_is(WCT, 8'hf1 | 8'(m) << 2);
      chk(wMode, m);
    end
    put(WCT, 8'h03);
    tick(3);
    @(posedge clk);
    busy <= 1'h1;
    put(WCT, 8'h07);
    tick(5);
    chk(wMode, EBC_WAIT_PROGRAMMABLE);
    @(posedge clk);
    busy <= 1'h0;
    tick(3);
    chk(wMode, EBC_WAIT_NONE);
  endtask

  task automatic t_release();
    @(posedge clk);
    want <= 1'h1;
    tick(12);
    chk(ackN, 1'h1);
    @(posedge clk);
    want <= 1'h0;
    tick(8);
    put(BRC, 8'h01);
    reg_is(BRC, 8'hff);
    tick(3);
    chk({relGpio, addrEn}, 4'h0);
    @(posedge clk);
    want <= 1'h1;
    for (int i = 0; i < 20 && ackN !== 1'h0; i++) tick(1);
    chk(ackN, 1'h0);
    @(posedge clk);
    want <= 1'h0;
    for (int i = 0; i < 40 && ackN !== 1'h1; i++) tick(1);
    chk(ackN, 1'h1);
  endtask

  task automatic t_standby();
    put(AST, 8'h00);
    @(posedge clk);
    hwStandby <= 1'h1;
    tick(4);
    @(posedge clk);
    hwStandby <= 1'h0;
    tick(4);
    reg_is(AST, 8'hff);
    reg_is(BRC, 8'hfe);
  endtask

  task automatic t_modes();
    reset_to(3'h3);
    reg_is(WID, 8'hff);
    put(BRC, 8'ha1);
    reg_is(BRC, 8'hbf);
    tick(3);
    chk(addrEn, 3'h2);
    reset_to(3'h2);
    reg_is(WID, 8'h00);
    chk(mode8, 1'h0);
    put(BRC, 8'h01);
    reg_is(BRC, 8'hff);
    reset_to(3'h4);
    reg_is(WID, 8'h00);
  endtask

  initial begin
    reset_to(3'h1);
    t_reset();
    t_access();
    t_wait_modes();
    t_release();
    t_standby();
    t_modes();
    stop_test();
  end
endmodule

`default_nettype wire
